// >>> hw/lspg_top.sv
// Output-side protection and gain control of a 16-channel LED sink driver, with an APB register slave.
// Assumes clock_i is a free-running 50 MHz time base; grayscale clock, load strobe and temperature
// comparators arrive as asynchronous pins; pwm_on_i comes from PWM logic on clock_i.
// Functional notes
// - With timeout enabled (bit 0 low), ~1 s without grayscale clock blanks all outputs.
// - After blanking, restart needs grayscale clock then new data; counters cleared first.
// - Configuration bits 9..2 form the 8-bit gain field, 256 levels.
// - Bit 9 selects current band: 0 low band, 1 high band.
// - Bits 8..2 are a 7-bit unsigned mantissa, MSB at bit 8.
// - Gain G = (3D+128)/256 high band, (3D+128)/1024 low band.
// - Four output groups by index mod four, each 40 ns after the previous.
// - Thermal foldback is off by default, active only when bit 1 is one.
// - Enabled and above 150 C: set thermal flag, current to 25 percent.
// - Below 110 C: clear thermal flag, restore full current; hysteresis.
`timescale 1ns/100ps
`default_nettype none
`include "lspg_defs.svh"

module lspg_top #(
  parameter logic [31:0] WDOG_CYCLES = `LSPG_WDOG_CYC
) (
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  input  wire lspg_pkg::lspg_apb_req_t apb_req_i,
  output var  lspg_pkg::lspg_apb_rsp_t apb_rsp_o,
  input  wire logic                   grayscale_clock_i,
  input  wire logic                   serial_load_i,
  input  wire logic                   temp_hot_i,
  input  wire logic                   temp_cool_i,
  input  wire logic [15:0]            pwm_on_i,
  output var  logic [15:0]            sink_output_o,
  output var  lspg_pkg::lspg_drive_t   drive_o,
  output var  logic                   irq_o
);
  import lspg_pkg::*;

  lspg_state_t st_ff;
  lspg_state_t nxt_st;

  logic        grayscale_clock_edge;
  logic        load_edge;
  logic        setup;
  logic        access;
  logic        hit_cfg;
  logic        hit_stat;
  logic        hit_mask;
  logic        hit_state;
  logic [15:0] wr_bits;
  logic [15:0] cfg_read;
  logic [`LSPG_IRQ_W-1:0] events;
  logic [11:0] mant_w;
  logic [11:0] gain_num;
  logic [11:0] gain_full;
  logic        tflag_nxt;

  always_comb begin
    nxt_st    = st_ff;
    events    = '0;
    wr_bits   = '0;

    // Pins pass two flops; only the second stage is looked at
    nxt_st.grayscale_clock_sync = {st_ff.grayscale_clock_sync[0], grayscale_clock_i};
    nxt_st.load_sync = {st_ff.load_sync[0], serial_load_i};
    nxt_st.hot_sync  = {st_ff.hot_sync[0], temp_hot_i};
    nxt_st.cool_sync = {st_ff.cool_sync[0], temp_cool_i};
    nxt_st.grayscale_clock_prev = st_ff.grayscale_clock_sync[1];
    nxt_st.load_prev = st_ff.load_sync[1];
    grayscale_clock_edge = st_ff.grayscale_clock_sync[1] ^ st_ff.grayscale_clock_prev;
    load_edge = st_ff.load_sync[1] & ~st_ff.load_prev;

    // Watchdog on the free-running base; saturates so a dead clock cannot wrap into a false restart
    if (grayscale_clock_edge) begin
      nxt_st.wdog_cnt = 32'h0;
    end else if (st_ff.wdog_cnt != WDOG_CYCLES) begin
      nxt_st.wdog_cnt = st_ff.wdog_cnt + 32'h1;
    end

    nxt_st.drv.counters_clear = 1'b0;
    if (!st_ff.drv.blank) begin
      // Greater-or-equal so a count saturated while the timeout was disabled still fires once re-enabled
      if (!st_ff.cfg[`LSPG_TODIS_BIT] && (st_ff.wdog_cnt >= WDOG_CYCLES - 32'h1) && !grayscale_clock_edge) begin
        nxt_st.drv.blank = 1'b1;
        nxt_st.seen_grayscale_clock = 1'b0;
        events[`LSPG_IRQ_LOSS] = 1'b1;
      end
    end else begin
      // Clock must come back before fresh data counts as a restart
      if (grayscale_clock_edge) begin
        nxt_st.seen_grayscale_clock = 1'b1;
      end
      if (st_ff.seen_grayscale_clock && load_edge && !st_ff.drv.counters_clear) begin
        nxt_st.drv.counters_clear = 1'b1;
      end
      if (st_ff.drv.counters_clear) begin
        nxt_st.drv.blank = 1'b0;
      end
    end

    // Thermal flag with hysteresis; forced clear while foldback is disabled
    tflag_nxt = st_ff.drv.foldback;
    if (!st_ff.cfg[`LSPG_TPEN_BIT]) begin
      tflag_nxt = 1'b0;
    end else if (!st_ff.drv.foldback && st_ff.hot_sync[1]) begin
      tflag_nxt = 1'b1;
      events[`LSPG_IRQ_HOT] = 1'b1;
    end else if (st_ff.drv.foldback && st_ff.cool_sync[1]) begin
      tflag_nxt = 1'b0;
      events[`LSPG_IRQ_COOL] = 1'b1;
    end
    nxt_st.drv.foldback = tflag_nxt;

    // Gain decode: one-bit exponent, seven-bit mantissa
    nxt_st.drv.band     = st_ff.cfg[`LSPG_BAND_BIT];
    nxt_st.drv.mantissa = st_ff.cfg[`LSPG_MANT_MSB:`LSPG_GAIN_LSB];
    mant_w    = {5'h00, st_ff.cfg[`LSPG_MANT_MSB:`LSPG_GAIN_LSB]};
    gain_num  = (mant_w << 1) + mant_w + `LSPG_GAIN_OFFSET;
    gain_full = st_ff.cfg[`LSPG_BAND_BIT] ? {gain_num[9:0], 2'b00} : gain_num;
    // Quarter current while folded back; the lost two bits only trim the lowest gain steps
    nxt_st.drv.gain_q10 = tflag_nxt ? {2'b00, gain_full[11:2]} : gain_full;

    // Stagger: group g is delayed 2g cycles more than group 0
    nxt_st.pipe[0] = pwm_on_i;
    for (int k = 1; k < `LSPG_PIPE_D; k++) begin
      nxt_st.pipe[k] = st_ff.pipe[k-1];
    end
    for (int ch = 0; ch < 16; ch++) begin
      if ((ch % 4) == 0) begin
        nxt_st.sink[ch] = pwm_on_i[ch] & ~st_ff.drv.blank;
      end else begin
        nxt_st.sink[ch] = st_ff.pipe[(ch % 4) * `LSPG_STAG_CYC - 1][ch] & ~st_ff.drv.blank;
      end
    end

    // APB slave: no wait state; ready and read data are registered in the setup phase so read data comes from a flop
    setup     = apb_req_i.psel & ~apb_req_i.penable;
    access    = apb_req_i.psel & apb_req_i.penable & st_ff.rsp.pready;
    hit_cfg   = apb_req_i.paddr == `LSPG_CFG_OFF;
    hit_stat  = apb_req_i.paddr == `LSPG_STAT_OFF;
    hit_mask  = apb_req_i.paddr == `LSPG_MASK_OFF;
    hit_state = apb_req_i.paddr == `LSPG_STATE_OFF;
    cfg_read  = {1'b0, st_ff.drv.foldback, `LSPG_RSV13_VAL, st_ff.cfg[12:0]};
    for (int b = 0; b < 2; b++) begin
      wr_bits[b*8 +: 8] = apb_req_i.pstrb[b] ? apb_req_i.pwdata[b*8 +: 8] : 8'h00;
    end

    nxt_st.rsp.pready = 1'b0;
    if (setup) begin
      nxt_st.rsp.pready  = 1'b1;
      nxt_st.rsp.pslverr = ~(hit_cfg | hit_stat | hit_mask | hit_state);
      nxt_st.rsp.prdata  = 32'h0;
      if (!apb_req_i.pwrite) begin
        unique case (1'b1)
          hit_cfg:   nxt_st.rsp.prdata = {16'h0000, cfg_read};
          hit_stat:  nxt_st.rsp.prdata = {29'h0, st_ff.stat};
          hit_mask:  nxt_st.rsp.prdata = {29'h0, st_ff.mask};
          hit_state: nxt_st.rsp.prdata = {28'h0, st_ff.seen_grayscale_clock, st_ff.drv.foldback,
                                          st_ff.drv.counters_clear, st_ff.drv.blank};
          default:   nxt_st.rsp.prdata = 32'h0;
        endcase
      end
    end else if (access) begin
      nxt_st.rsp.pslverr = 1'b0;
    end

    nxt_st.stat = st_ff.stat;
    if (access && apb_req_i.pwrite) begin
      if (hit_cfg) begin
        for (int b = 0; b < 2; b++) begin
          if (apb_req_i.pstrb[b]) begin
            nxt_st.cfg[b*8 +: 8] = 8'(wr_bits[b*8 +: 8] & (`LSPG_CFG_WMASK >> (b*8)));
          end
        end
      end
      if (hit_stat && apb_req_i.pstrb[0]) begin
        nxt_st.stat = st_ff.stat & ~wr_bits[`LSPG_IRQ_W-1:0];
      end
      if (hit_mask && apb_req_i.pstrb[0]) begin
        nxt_st.mask = wr_bits[`LSPG_IRQ_W-1:0];
      end
    end
    // New events win over a clear in the same cycle
    nxt_st.stat = nxt_st.stat | events;
    nxt_st.irq  = |(nxt_st.stat & nxt_st.mask);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff                     <= '0;
      st_ff.cfg                 <= `LSPG_CFG_RST & `LSPG_CFG_WMASK;
      st_ff.drv.band            <= 1'b1;
      st_ff.drv.mantissa        <= 7'h2B;
      st_ff.drv.gain_q10        <= 12'h404;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign apb_rsp_o     = st_ff.rsp;
  assign sink_output_o = st_ff.sink;
  assign drive_o       = st_ff.drv;
  assign irq_o         = st_ff.irq;

endmodule

`default_nettype wire

// >>> pkg/lspg_defs.svh
// Offsets, field positions, reset values and timing counts of the LED sink protection and gain block.
// Included by bare name; holds definitions only.
`ifndef LSPG_DEFS_SVH
`define LSPG_DEFS_SVH

`define LSPG_CFG_OFF      12'h000
`define LSPG_STAT_OFF     12'h004
`define LSPG_MASK_OFF     12'h008
`define LSPG_STATE_OFF    12'h00C

`define LSPG_CFG_RST      16'h3EAC
`define LSPG_CFG_WMASK    16'h1FFF
`define LSPG_TODIS_BIT    0
`define LSPG_TPEN_BIT     1
`define LSPG_GAIN_LSB     2
`define LSPG_MANT_MSB     8
`define LSPG_BAND_BIT     9
`define LSPG_RSV13_VAL    1'b1
`define LSPG_IRQ_W        3
`define LSPG_IRQ_LOSS     0
`define LSPG_IRQ_HOT      1
`define LSPG_IRQ_COOL     2

`define LSPG_GAIN_OFFSET  12'h080
`define LSPG_CLK_HZ       50000000
`define LSPG_CLK_NS       20
`define LSPG_WDOG_S       1
`define LSPG_WDOG_CYC     (`LSPG_WDOG_S * `LSPG_CLK_HZ)
`define LSPG_STAG_NS      40
`define LSPG_STAG_CYC     ((`LSPG_STAG_NS + `LSPG_CLK_NS - 1) / `LSPG_CLK_NS)
`define LSPG_PIPE_D       (3 * `LSPG_STAG_CYC)

`endif

// >>> pkg/lspg_pkg.sv
// Types of the LED sink protection and gain block.
// Assumes lspg_defs.svh is on the include path.
`include "lspg_defs.svh"

package lspg_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } lspg_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } lspg_apb_rsp_t;

  typedef struct packed {
    logic        blank;
    logic        foldback;
    logic        band;
    logic [6:0]  mantissa;
    logic [11:0] gain_q10;
    logic        counters_clear;
  } lspg_drive_t;

  typedef struct packed {
    logic [1:0]                     grayscale_clock_sync;
    logic [1:0]                     load_sync;
    logic [1:0]                     hot_sync;
    logic [1:0]                     cool_sync;
    logic                           grayscale_clock_prev;
    logic                           load_prev;
    logic [31:0]                    wdog_cnt;
    logic                           seen_grayscale_clock;
    logic [15:0]                    cfg;
    logic [`LSPG_IRQ_W-1:0]         stat;
    logic [`LSPG_IRQ_W-1:0]         mask;
    logic                           irq;
    logic [`LSPG_PIPE_D-1:0][15:0]  pipe;
    logic [15:0]                    sink;
    lspg_drive_t                    drv;
    lspg_apb_rsp_t                  rsp;
  } lspg_state_t;

endpackage

// >>> bench/lspg_sva.sv
// Port checker of the LED sink protection block.
// Bound into lspg_top; one clock, async low reset.
`timescale 1ns/100ps
`default_nettype none
module lspg_sva #(
  parameter logic [31:0] WDOG_CYCLES = 32'd50
) (
  input wire logic                    clock_i,
  input wire logic                    rst_n_i,
  input wire lspg_pkg::lspg_apb_req_t apb_req_i,
  input wire lspg_pkg::lspg_apb_rsp_t apb_rsp_o,
  input wire logic                    grayscale_clock_i,
  input wire logic                    temp_hot_i,
  input wire logic [15:0]             pwm_on_i,
  input wire logic [15:0]             sink_output_o,
  input wire lspg_pkg::lspg_drive_t   drive_o
);
  import lspg_pkg::*;
  logic [31:0] quiet_ff;
  logic        gprev_ff;
  logic [11:0] base;
  assign base = 12'(drive_o.mantissa) * 12'h003 + 12'h080;
  // Counts from the pin, so sync latency only adds margin
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet_ff <= '0;
      gprev_ff <= 1'b0;
    end else begin
      quiet_ff <= (grayscale_clock_i != gprev_ff) ? '0 : quiet_ff + 32'h1;
      gprev_ff <= grayscale_clock_i;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_restart;
    drive_o.counters_clear ##1 (!drive_o.counters_clear && !drive_o.blank);
  endsequence
  property p_blank; drive_o.blank |=> sink_output_o == 16'h0000; endproperty
  a_blank: assert property (p_blank) else $error("sink on while blanked");
  property p_quiet; $rose(drive_o.blank) |-> quiet_ff >= WDOG_CYCLES - 32'h1; endproperty
  a_quiet: assert property (p_quiet) else $error("blank too early");
  property p_clr; $fell(drive_o.blank) |-> $past(drive_o.counters_clear); endproperty
  a_clr: assert property (p_clr) else $error("unblank without clear");
  property p_restart; drive_o.counters_clear |-> s_restart; endproperty
  a_restart: assert property (p_restart) else $error("bad restart");
  property p_gain; drive_o.gain_q10 == ((drive_o.band ? base << 2 : base) >> (drive_o.foldback ? 2 : 0)); endproperty
  a_gain: assert property (p_gain) else $error("gain mismatch");
  property p_stag; $past(rst_n_i, 8) && !drive_o.blank |=> sink_output_o[3:0] == {$past(pwm_on_i[3], 7),
    $past(pwm_on_i[2], 5), $past(pwm_on_i[1], 3), $past(pwm_on_i[0])}; endproperty
  a_stag: assert property (p_stag) else $error("stagger wrong");
  property p_hot; $rose(drive_o.foldback) |-> $past(temp_hot_i, 3); endproperty
  a_hot: assert property (p_hot) else $error("foldback without heat");
  property p_rdy; apb_req_i.psel && !apb_req_i.penable |=> apb_rsp_o.pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
endmodule
bind lspg_top lspg_sva #(.WDOG_CYCLES(WDOG_CYCLES)) i_sva (.clock_i, .rst_n_i, .apb_req_i, .apb_rsp_o,
  .grayscale_clock_i, .temp_hot_i, .pwm_on_i, .sink_output_o, .drive_o);
`default_nettype wire

// >>> bench/lspg_host.sv
// Host model: grayscale clock and serial load strobe.
// Shares the block clock; pins change just after rising edges.
`timescale 1ns/100ps
`default_nettype none
module lspg_host (
  input  wire logic clock_i,
  input  wire logic run_i,
  input  wire logic load_req_i,
  output var  logic grayscale_clock_o,
  output var  logic serial_load_o
);
  initial grayscale_clock_o = 1'b0;
  // Stopped clock stands still, as a host losing its source would
  always @(posedge clock_i) begin
    if (run_i)
      grayscale_clock_o <= ~grayscale_clock_o;
    serial_load_o <= load_req_i;
  end
endmodule
`default_nettype wire

// >>> bench/tb_led_sink_protect_gain.sv
// Bench of the LED sink protection block: APB master, host model, scenario tasks.
// Assumes package, design, checker and host model compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "lspg_defs.svh"
module tb_led_sink_protect_gain;
  import lspg_pkg::*;
  localparam logic [31:0] WD = 32'd50;
  logic          clock_i, rst_n_i, run, load_req, hot, cool, grayscale_clock, load, irq, err;
  logic [15:0]   pwm, sink;
  logic [31:0]   rd;
  lspg_apb_req_t req;
  lspg_apb_rsp_t rsp;
  lspg_drive_t   drv;
  int            n_errors, n_tests;
  lspg_host i_host (.clock_i, .run_i(run), .load_req_i(load_req), .grayscale_clock_o(grayscale_clock), .serial_load_o(load));
  lspg_top #(.WDOG_CYCLES(WD)) i_dut (.clock_i, .rst_n_i, .apb_req_i(req), .apb_rsp_o(rsp),
    .grayscale_clock_i(grayscale_clock), .serial_load_i(load), .temp_hot_i(hot), .temp_cool_i(cool),
    .pwm_on_i(pwm), .sink_output_o(sink), .drive_o(drv), .irq_o(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Reads sample before the edge's updates land, so no race with the design
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    req <= '{1'b1, 1'b0, wr, a, d, 4'hF};
    @(posedge clock_i);
    req.penable <= 1'b1;
    // Waits as long as the slave needs; only the bench time limit at 100000 ns ends a hang
    do begin
      @(posedge clock_i);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic t_gain();
    logic [7:0]  c [5] = '{8'h00, 8'h7F, 8'h80, 8'hC0, 8'hFF};
    logic [11:0] g;
    apb(1'b0, `LSPG_CFG_OFF, 32'h0);
    chk(rd, 32'h0000_3EAC);
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1);
    foreach (c[i]) begin
      apb(1'b1, `LSPG_CFG_OFF, 32'h1C00 | {22'h0, c[i], 2'h0});
      repeat (3) @(posedge clock_i);
      g = 12'(c[i][6:0]) * 12'h003 + 12'h080;
      g = c[i][7] ? g << 2 : g;
      chk(drv.band, c[i][7]);
      chk(drv.mantissa, c[i][6:0]);
      chk(drv.gain_q10, g);
      apb(1'b0, `LSPG_CFG_OFF, 32'h0);
      chk(rd[9:2], c[i]);
    end
    $display("gain test done");
  endtask
  task automatic t_stag();
    pwm <= 16'hFFFF;
    for (int k = 0; k < 9; k++) begin
      @(posedge clock_i);
      chk(sink, {4{k >= 7, k >= 5, k >= 3, k >= 1}});
    end
    pwm <= 16'h0000;
    $display("stagger test done");
  endtask
  task automatic t_therm();
    hot <= 1'b1;
    repeat (6) @(posedge clock_i);
    chk(drv.foldback, 1'b0);
    apb(1'b1, `LSPG_CFG_OFF, 32'h3EAE);
    repeat (6) @(posedge clock_i);
    chk(drv.foldback, 1'b1);
    chk(drv.gain_q10, 12'h101);
    chk(irq, 1'b0);
    apb(1'b0, `LSPG_STAT_OFF, 32'h0);
    chk(rd, 32'h0000_0002);
    apb(1'b1, `LSPG_MASK_OFF, 32'h2);
    repeat (2) @(posedge clock_i);
    chk(irq, 1'b1);
    hot <= 1'b0;
    cool <= 1'b1;
    repeat (6) @(posedge clock_i);
    chk(drv.foldback, 1'b0);
    apb(1'b1, `LSPG_STAT_OFF, 32'h7);
    repeat (2) @(posedge clock_i);
    chk(irq, 1'b0);
    $display("thermal test done");
  endtask
  task automatic t_wdog();
    int n;
    pwm <= 16'hFFFF;
    run <= 1'b0;
    n = 0;
    while (drv.blank !== 1'b1 && n < 200) begin
      @(posedge clock_i);
      n++;
    end
    chk(n >= WD && n <= WD + 6, 1'b1);
    @(posedge clock_i);
    chk(sink, 16'h0000);
    apb(1'b0, `LSPG_STATE_OFF, 32'h0);
    chk(rd, 32'h0000_0001);
    run <= 1'b1;
    repeat (8) @(posedge clock_i);
    chk(drv.blank, 1'b1);
    load_req <= 1'b1;
    @(posedge clock_i);
    load_req <= 1'b0;
    repeat (8) @(posedge clock_i);
    chk(drv.blank, 1'b0);
    apb(1'b1, `LSPG_CFG_OFF, 32'h3EAD);
    run <= 1'b0;
    repeat (120) @(posedge clock_i);
    chk(drv.blank, 1'b0);
    $display("watchdog test done");
  endtask
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
  initial begin
    {rst_n_i, load_req, hot, cool, pwm, req} = '0;
    run = 1'b1;
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_gain();
    t_stag();
    t_therm();
    t_wdog();
    print_verdict();
  end
endmodule
`default_nettype wire
